// ==== pkg/pdiv_defs.vh ====
`ifndef PDIV_DEFS_VH
`define PDIV_DEFS_VH

// ----------------------------------------------------------------------
// Programming word layout, first serial bit in the top position.
// ----------------------------------------------------------------------
`define PDIV_PROG_W 20
`define PDIV_PROG_RST 20'h00100
`define PDIV_REF_HI_MSB 19
`define PDIV_REF_HI_LSB 18
`define PDIV_MAIN_HI_MSB 17
`define PDIV_MAIN_HI_LSB 16
`define PDIV_BYPASS_BIT 15
`define PDIV_MAIN_LO_MSB 14
`define PDIV_MAIN_LO_LSB 8
`define PDIV_REF_LO_MSB 7
`define PDIV_REF_LO_LSB 4
`define PDIV_SWAL_MSB 3
`define PDIV_SWAL_LSB 0

// ----------------------------------------------------------------------
// Counter widths and prescaler terminal counts.
// ----------------------------------------------------------------------
`define PDIV_MAIN_W 9
`define PDIV_REF_W 6
`define PDIV_SWAL_W 4
`define PDIV_PRE_W 4
`define PDIV_PRE_LAST_LOW 4'h9
`define PDIV_PRE_LAST_HIGH 4'ha

// ----------------------------------------------------------------------
// Register map on the bus, byte addresses.
// ----------------------------------------------------------------------
`define PDIV_ADDR_W 4
`define PDIV_OFF_CTRL 4'h0
`define PDIV_OFF_PROG 4'h4
`define PDIV_OFF_STATUS 4'h8
`define PDIV_CTRL_RST 1'h1
`define PDIV_CTRL_RUN_BIT 0
`define PDIV_HTRANS_NONSEQ_BIT 1

`endif

// ==== core/pdiv_pin_sync.v ====
// Brings one pin into the hclk domain through three flip-flops.
// The filtered level only moves once the second and third stages agree,
// and a one-cycle pulse marks each accepted rising change.
module pdiv_pin_sync (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Pin and results.
  input wire pin,
  output reg level,
  output reg rise
);

  reg stage1;
  reg stage2;
  reg stage3;

  // Three-stage capture; only stage2 reads stage1.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a change only when the two later stages agree.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      level <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      rise <= 1'b0;
      if (stage2 == stage3 && stage3 != level)
      begin
        level <= stage3;
        rise <= stage3;
      end
    end
  end

endmodule

// ==== core/pdiv_phase_det.v ====
// Phase-frequency detector fed by the two divided event pulses.
// Whichever divided signal arrives first opens its pulse; the arrival of
// the other one closes both, so the width tracks the phase offset.
module pdiv_phase_det (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Divided events, one-cycle pulses.
  input wire main_tick,
  input wire ref_tick,
  // Charge pump steering, active low.
  output wire up_pulse_n,
  output wire down_pulse_n
);

  reg up_open;
  reg down_open;

  // Open on the leading edge, clear both once the lagging edge arrives.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      up_open <= 1'b0;
      down_open <= 1'b0;
    end
    else if ((main_tick || down_open) && (ref_tick || up_open))
    begin
      up_open <= 1'b0;
      down_open <= 1'b0;
    end
    else
    begin
      if (ref_tick)
        up_open <= 1'b1;
      if (main_tick)
        down_open <= 1'b1;
    end
  end

  // Separate up and down controls for the charge pump.
  assign up_pulse_n = ~up_open;
  assign down_pulse_n = ~down_open;

endmodule

// ==== core/pdiv_chain.v ====
`include "pdiv_defs.vh"

// ----------------------------------------------------------------------
// Divider chain of an integer-N synthesizer with bus access.
// ----------------------------------------------------------------------

// Overview of operation
// - Prescaler divides by ten or eleven.
// - All divide values from one 20-bit word.
// - Swallow counter drives the modulus select.
// - Bypass low enables prescaler, main plus swallow.
// - Main output equals input over 10(M+1)+A.
// - Main value 1 to 511, divides M+1.
// - Swallow up to 15, keep within M+1.
// - Bypass high skips prescaler, divides M+1.
// - Reference output is input over R+1.
// - Reference value zero passes input through.
// - Detector gives separate up and down.
// - Programming word loads only from serial pins.
// - Leading divided edge opens its low pulse.
module pdiv_chain (
  // Bus clock and reset.
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave port.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Analog-side inputs, asynchronous pins.
  input wire rf_input,
  input wire reference_input,
  // Three-wire serial programming pins.
  input wire serial_clk,
  input wire serial_data,
  input wire serial_load,
  // Divided outputs and modulus select.
  output reg main_chain_output,
  output reg compare_ref_output,
  output reg divide_choice_signal,
  // Phase detector outputs.
  output wire up_pulse_n,
  output wire down_pulse_n
);

  // ----------------------------------------------------------------------
  // Pin capture.
  // ----------------------------------------------------------------------
  wire rf_tick;
  wire ref_in_tick;
  wire sclk_rise;
  wire sdata_level;
  wire load_rise;

  // Each asynchronous pin gets its own three-stage synchroniser.
  pdiv_pin_sync u_sync_rf (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(rf_input),
    .level(),
    .rise(rf_tick)
  );

  pdiv_pin_sync u_sync_ref (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(reference_input),
    .level(),
    .rise(ref_in_tick)
  );

  pdiv_pin_sync u_sync_sclk (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(serial_clk),
    .level(),
    .rise(sclk_rise)
  );

  pdiv_pin_sync u_sync_sdata (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(serial_data),
    .level(sdata_level),
    .rise()
  );

  pdiv_pin_sync u_sync_load (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(serial_load),
    .level(),
    .rise(load_rise)
  );

  // ----------------------------------------------------------------------
  // Serial programming word.
  // ----------------------------------------------------------------------
  reg [`PDIV_PROG_W-1:0] shift_word;
  reg [`PDIV_PROG_W-1:0] prog_word;

  // Data enters first bit first; the load strobe commits the whole word.
  // The bus has no path into this word, so software cannot corrupt it.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift_word <= `PDIV_PROG_RST;
      prog_word <= `PDIV_PROG_RST;
    end
    else
    begin
      if (sclk_rise)
        shift_word <= {shift_word[`PDIV_PROG_W-2:0], sdata_level};
      if (load_rise)
        prog_word <= shift_word;
    end
  end

  // Field extraction from the single programming word.
  wire [`PDIV_MAIN_W-1:0] main_value;
  wire [`PDIV_REF_W-1:0] ref_value;
  wire [`PDIV_SWAL_W-1:0] swallow_value;
  wire bypass;

  assign main_value = {prog_word[`PDIV_MAIN_HI_MSB:`PDIV_MAIN_HI_LSB],
                       prog_word[`PDIV_MAIN_LO_MSB:`PDIV_MAIN_LO_LSB]};
  assign ref_value = {prog_word[`PDIV_REF_HI_MSB:`PDIV_REF_HI_LSB],
                      prog_word[`PDIV_REF_LO_MSB:`PDIV_REF_LO_LSB]};
  assign swallow_value = prog_word[`PDIV_SWAL_MSB:`PDIV_SWAL_LSB];
  assign bypass = prog_word[`PDIV_BYPASS_BIT];

  // ----------------------------------------------------------------------
  // Bus control register.
  // ----------------------------------------------------------------------
  reg run;
  wire halt;

  assign halt = ~run;

  // ----------------------------------------------------------------------
  // Dual-modulus prescaler.
  // ----------------------------------------------------------------------
  reg [`PDIV_PRE_W-1:0] pre_count;
  wire [`PDIV_PRE_W-1:0] pre_last;
  wire pre_tick;

  // The terminal count follows the modulus select: ten or eleven inputs.
  assign pre_last = divide_choice_signal ? `PDIV_PRE_LAST_HIGH : `PDIV_PRE_LAST_LOW;
  assign pre_tick = rf_tick && !bypass && (pre_count == pre_last);

  // Prescaler count; held in reset while bypassed to mimic power down.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_count <= {`PDIV_PRE_W{1'b0}};
    else if (halt || bypass)
      pre_count <= {`PDIV_PRE_W{1'b0}};
    else if (rf_tick)
    begin
      if (pre_count == pre_last)
        pre_count <= {`PDIV_PRE_W{1'b0}};
      else
        pre_count <= pre_count + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Main and swallow counters.
  // ----------------------------------------------------------------------
  reg [`PDIV_MAIN_W-1:0] main_count;
  reg [`PDIV_SWAL_W-1:0] swallow_count;
  wire main_step;
  wire main_wrap;

  // In bypass the main counter steps on every RF edge directly.
  assign main_step = bypass ? rf_tick : pre_tick;
  assign main_wrap = main_step && (main_count == {`PDIV_MAIN_W{1'b0}});

  // Main counter runs M down to zero: M+1 steps per output cycle.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      main_count <= {`PDIV_MAIN_W{1'b0}};
    else if (halt)
      main_count <= main_value;
    else if (main_step)
    begin
      if (main_count == {`PDIV_MAIN_W{1'b0}})
        main_count <= main_value;
      else
        main_count <= main_count - 1'b1;
    end
  end

  // Swallow counter counts eleven-periods left in this main cycle.
  // It reloads at every main wrap, which also bounds it when A > M+1.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      swallow_count <= {`PDIV_SWAL_W{1'b0}};
    else if (halt || bypass)
      swallow_count <= swallow_value;
    else if (main_wrap)
      swallow_count <= swallow_value;
    else if (pre_tick && swallow_count != {`PDIV_SWAL_W{1'b0}})
      swallow_count <= swallow_count - 1'b1;
  end

  // Modulus select asks for eleven while swallow periods remain.
  // It is never asserted in bypass, whatever the swallow value holds.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      divide_choice_signal <= 1'b0;
    else if (halt || bypass)
      divide_choice_signal <= 1'b0;
    else if (main_wrap)
      divide_choice_signal <= (swallow_value != {`PDIV_SWAL_W{1'b0}});
    else if (pre_tick)
      divide_choice_signal <= (swallow_count > {{(`PDIV_SWAL_W-1){1'b0}}, 1'b1});
  end

  // One output pulse per main cycle: 10(M+1)+A or M+1 RF edges apart.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      main_chain_output <= 1'b0;
    else
      main_chain_output <= main_wrap && !halt;
  end

  // ----------------------------------------------------------------------
  // Reference counter.
  // ----------------------------------------------------------------------
  reg [`PDIV_REF_W-1:0] ref_count;
  wire ref_wrap;

  // With a zero value every reference edge wraps, passing it through.
  assign ref_wrap = ref_in_tick && (ref_count == {`PDIV_REF_W{1'b0}});

  // Counts R down to zero: one output per R+1 reference edges.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ref_count <= {`PDIV_REF_W{1'b0}};
    else if (halt)
      ref_count <= ref_value;
    else if (ref_in_tick)
    begin
      if (ref_count == {`PDIV_REF_W{1'b0}})
        ref_count <= ref_value;
      else
        ref_count <= ref_count - 1'b1;
    end
  end

  // Registered comparison pulse.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      compare_ref_output <= 1'b0;
    else
      compare_ref_output <= ref_wrap && !halt;
  end

  // ----------------------------------------------------------------------
  // Phase detector.
  // ----------------------------------------------------------------------
  pdiv_phase_det u_phase_det (
    .hclk(hclk),
    .hresetn(hresetn),
    .main_tick(main_chain_output),
    .ref_tick(compare_ref_output),
    .up_pulse_n(up_pulse_n),
    .down_pulse_n(down_pulse_n)
  );

  // ----------------------------------------------------------------------
  // AHB-Lite slave.
  // ----------------------------------------------------------------------
  reg wr_pending;
  reg [`PDIV_ADDR_W-1:0] wr_addr;
  wire take;

  // The slave never stalls and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel && hready && htrans[`PDIV_HTRANS_NONSEQ_BIT];

  // Read mux shared by the read path.
  function [31:0] read_word;
    input [`PDIV_ADDR_W-1:0] addr;
    begin
      if (addr == `PDIV_OFF_CTRL)
        read_word = {31'h0, run};
      else if (addr == `PDIV_OFF_PROG)
        read_word = {12'h000, prog_word};
      else if (addr == `PDIV_OFF_STATUS)
        read_word = {27'h0, down_pulse_n, up_pulse_n, compare_ref_output,
                     main_chain_output, divide_choice_signal};
      else
        read_word = 32'h00000000;
    end
  endfunction

  // Address phase capture; read data is prepared for the data phase.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending <= 1'b0;
      wr_addr <= {`PDIV_ADDR_W{1'b0}};
      hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pending <= take && hwrite;
      if (take)
        wr_addr <= haddr[`PDIV_ADDR_W-1:0];
      if (take && !hwrite && haddr[31:`PDIV_ADDR_W] == 28'h0000000)
        hrdata <= read_word(haddr[`PDIV_ADDR_W-1:0]);
      else if (take)
        hrdata <= 32'h00000000;
    end
  end

  // Data phase write; only the control word is writable from the bus.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      run <= `PDIV_CTRL_RST;
    else if (wr_pending && wr_addr == `PDIV_OFF_CTRL)
      run <= hwdata[`PDIV_CTRL_RUN_BIT];
  end

endmodule

// ==== tb/pdiv_chk.sv ====
module pdiv_chk (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Divided outputs and detector.
  input wire main_chain_output,
  input wire compare_ref_output,
  input wire divide_choice_signal,
  input wire up_pulse_n,
  input wire down_pulse_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------------
  // Output relations, all in the bus clock domain.
  // -------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_main_lone: assert property (
    main_chain_output |=> !main_chain_output [*8]) else $error("main pulse not alone");
  chk_ref_lone: assert property (
    compare_ref_output |=> !compare_ref_output [*4]) else $error("reference pulse not alone");
  chk_down_opens: assert property (
    main_chain_output && !compare_ref_output && up_pulse_n |=> !down_pulse_n) else $error("down did not open");
  chk_up_opens: assert property (
    compare_ref_output && !main_chain_output && down_pulse_n |=> !up_pulse_n) else $error("up did not open");
  chk_close_both: assert property (
    (main_chain_output && !up_pulse_n) || (compare_ref_output && !down_pulse_n) |=> up_pulse_n && down_pulse_n)
    else $error("detector did not close");
  chk_never_both: assert property (
    up_pulse_n || down_pulse_n) else $error("up and down low together");
  chk_up_holds: assert property (
    !up_pulse_n && !main_chain_output |=> !up_pulse_n) else $error("up released early");
  chk_down_holds: assert property (
    !down_pulse_n && !compare_ref_output |=> !down_pulse_n) else $error("down released early");
  chk_choice_long: assert property (
    $rose(divide_choice_signal) |=> divide_choice_signal [*8]) else $error("modulus select too short");

  // Main scenarios reached.
  cov_main: cover property (main_chain_output);
  cov_choice: cover property ($rose(divide_choice_signal));
  cov_up: cover property (!up_pulse_n);
  cov_down: cover property (!down_pulse_n);
endmodule

bind pdiv_chain pdiv_chk u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .main_chain_output(main_chain_output),
  .compare_ref_output(compare_ref_output),
  .divide_choice_signal(divide_choice_signal),
  .up_pulse_n(up_pulse_n),
  .down_pulse_n(down_pulse_n)
);

// ==== tb/pdiv_far_end.sv ====
module pdiv_far_end (
  // Clock and source enables.
  input wire hclk,
  input wire rf_run,
  input wire ref_run,
  // Driven pins.
  output logic rf_input,
  output logic reference_input,
  output logic serial_clk,
  output logic serial_data,
  output logic serial_load
);
  timeunit 1ns;
  timeprecision 1ps;
  int rf_cnt = 0;
  int ref_cnt = 0;

  // Pins start quiet; a halted source stands still at its level.
  initial
  begin
    rf_input = 1'b0;
    reference_input = 1'b0;
    serial_clk = 1'b0;
    serial_data = 1'b0;
    serial_load = 1'b0;
  end

  // RF toggles every 4 cycles, reference every 5, both slower than hclk/6.
  always @(posedge hclk)
  begin
    rf_cnt <= rf_run ? (rf_cnt + 1) % 4 : rf_cnt;
    ref_cnt <= ref_run ? (ref_cnt + 1) % 5 : ref_cnt;
    if (rf_run && rf_cnt == 3)
      rf_input <= ~rf_input;
    if (ref_run && ref_cnt == 4)
      reference_input <= ~reference_input;
  end

  // Sends the whole 20-bit word first bit on top, then commits it.
  task automatic load_word(input logic [19:0] w);
    for (int i = 19; i >= 0; i--)
    begin
      @(posedge hclk);
      serial_data <= w[i];
      repeat (5) @(posedge hclk);
      serial_clk <= 1'b1;
      repeat (5) @(posedge hclk);
      serial_clk <= 1'b0;
      repeat (5) @(posedge hclk);
    end
    serial_data <= ~w[0];
    serial_load <= 1'b1;
    repeat (5) @(posedge hclk);
    serial_load <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask
endmodule

// ==== tb/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, rf_run, ref_run;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hreadyout, hresp, rf_in, ref_in, sclk, sdat, sload;
  wire main_o, cmp_o, choice, up_n, down_n;
  wire [31:0] hrdata;
  int miscompares = 0, n_compared = 0;
  int rf_tot = 0, rf_last = 0, hi_tot = 0, hi_last = 0, ref_tot = 0, ref_last = 0;
  int main_per = 0, hi_per = 0, ref_per = 0, main_seen = 0, ref_seen = 0;

  pdiv_chain DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rf_input(rf_in), .reference_input(ref_in), .serial_clk(sclk),
    .serial_data(sdat), .serial_load(sload), .main_chain_output(main_o), .compare_ref_output(cmp_o),
    .divide_choice_signal(choice), .up_pulse_n(up_n), .down_pulse_n(down_n));
  pdiv_far_end far (.hclk(hclk), .rf_run(rf_run), .ref_run(ref_run), .rf_input(rf_in),
    .reference_input(ref_in), .serial_clk(sclk), .serial_data(sdat), .serial_load(sload));

  // Clock of 4 ns.
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Edge counters; periods are taken in input rises between output pulses.
  always @(posedge rf_in)
  begin
    rf_tot++;
    if (choice === 1'b1)
      hi_tot++;
  end
  always @(posedge ref_in)
    ref_tot++;
  always @(posedge hclk)
  begin
    if (main_o === 1'b1)
    begin
      main_per = rf_tot - rf_last;
      hi_per = hi_tot - hi_last;
      rf_last = rf_tot;
      hi_last = hi_tot;
      main_seen++;
    end
    if (cmp_o === 1'b1)
    begin
      ref_per = ref_tot - ref_last;
      ref_last = ref_tot;
      ref_seen++;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Programming word; callers keep M in 1..511 and A within M+1.
  function automatic logic [19:0] mk(input int r, input int m, input int b, input int a);
    return {r[5:4], m[8:7], b[0], m[6:0], r[3:0], a[3:0]};
  endfunction

  // One AHB-Lite single transfer; read data taken at the data-phase edge.
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task wait_pulses(input bit use_ref, input int k);
    int start;
    start = use_ref ? ref_seen : main_seen;
    repeat (20000)
    begin
      @(posedge hclk);
      if ((use_ref ? ref_seen : main_seen) - start >= k)
        break;
    end
    // A wait that runs out is a mismatch, so a stale period cannot pass unnoticed.
    if ((use_ref ? ref_seen : main_seen) - start < k)
    begin
      miscompares++;
      $display("unexpected at %0t: divided pulses did not arrive", $time);
    end
  endtask

  task t_regs;
    ahb(1'b0, 32'h0, 32'h0);
    check(rd, 32'h1);
    ahb(1'b0, 32'h4, 32'h0);
    check(rd, 32'h00100);
    ahb(1'b1, 32'h4, 32'h000fffff);
    check(hresp, 1'b0);
    ahb(1'b0, 32'h4, 32'h0);
    check(rd, 32'h00100);
    ahb(1'b0, 32'hc, 32'h0);
    check(rd, 32'h0);
  endtask

  task t_bypass;
    far.load_word(mk(0, 3, 1, 4));
    wait_pulses(1'b0, 3);
    check(main_per, 4);
    check(hi_per, 0);
    ahb(1'b0, 32'h4, 32'h0);
    check(rd, {12'h0, mk(0, 3, 1, 4)});
  endtask

  task t_prescale;
    int tm[3] = '{1, 1, 2};
    int ta[3] = '{0, 2, 3};
    for (int i = 0; i < 3; i++)
    begin
      far.load_word(mk(0, tm[i], 0, ta[i]));
      wait_pulses(1'b0, 3);
      check(main_per, 10 * (tm[i] + 1) + ta[i]);
      check(hi_per, 11 * ta[i]);
    end
  endtask

  task t_reference;
    int tr[3] = '{0, 5, 63};
    ref_run <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      far.load_word(mk(tr[i], 1, 1, 0));
      wait_pulses(1'b1, 3);
      check(ref_per, tr[i] + 1);
    end
    ref_run <= 1'b0;
  endtask

  task t_run;
    int start;
    ahb(1'b1, 32'h0, 32'h0);
    // A pulse launched at the stopping edge is still counted one edge later.
    repeat (2) @(posedge hclk);
    start = main_seen;
    repeat (200) @(posedge hclk);
    check(main_seen - start, 0);
    ahb(1'b1, 32'h0, 32'h1);
    wait_pulses(1'b0, 3);
    check(main_per, 2);
  endtask

  task t_detector;
    wait_pulses(1'b0, 3);
    check({down_n, up_n}, 2'b01);
    ahb(1'b0, 32'h8, 32'h0);
    check(rd[4:3], 2'b01);
    rf_run <= 1'b0;
    ref_run <= 1'b1;
    wait_pulses(1'b1, 3);
    check({down_n, up_n}, 2'b10);
    ahb(1'b0, 32'h8, 32'h0);
    check(rd[4:3], 2'b10);
  endtask

  task give_verdict;
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog at 50,000 cycles, well above the expected run.
  initial
  begin
    #200us;
    miscompares++;
    give_verdict;
  end

  // Main sequence.
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rf_run = 1'b1;
    ref_run = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_bypass;
    t_prescale;
    t_reference;
    t_run;
    t_detector;
    give_verdict;
  end
endmodule
